// >>> common/asrb_pkg.sv
// constants shared by the angle sensor host register bank and its turns counter
//=============================================================
//=============================================================
package asrb_pkg;
   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 13;
   localparam int ANG_W  = 12;
   localparam int TRN_W  = 12;
   localparam int FLT_W  = 7;
   localparam int CTL_W  = 5;
   localparam int OCT_W  = 3;

   //=============================================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_ANGLE  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TURNS  = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_FLT1   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FLT2   = 8'h05;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_UNLOCK = 8'h0f;

   //=============================================================
   // primary fault flag positions
   localparam int FP_SUPPLY   = 0;
   localparam int FP_MAGNET   = 1;
   localparam int FP_INTERNAL = 2;
   localparam int FP_REV_OVF  = 3;
   localparam int FP_OVERHEAT = 4;
   localparam int FP_NVM_FIX  = 5;
   localparam int FP_NVM_BAD  = 6;
   // secondary fault flag positions
   localparam int FS_RES0     = 0;
   localparam int FS_RES1     = 1;
   localparam int FS_SENSOR   = 3;
   localparam int FS_LOGIC    = 4;
   localparam int FS_LINK     = 6;
   // control field positions
   localparam int CB_FLT_CLR  = 0;
   localparam int CB_SLEEP    = 1;
   localparam int CB_RPM      = 2;
   localparam int CB_TRN_CLR  = 3;
   localparam int CB_SELFTEST = 4;
   // angle field starts above the always-zero bit
   localparam int ANG_LSB     = 1;

   //=============================================================
   // reset values and implemented-bit masks
   localparam logic [FLT_W-1:0] FLT1_RST  = 7'h01;
   localparam logic [FLT_W-1:0] FLT2_RST  = 7'h01;
   localparam logic [FLT_W-1:0] FLT2_IMPL = 7'h5b;
   localparam logic [ANG_W-1:0] ANG_RST   = 12'h000;
   localparam logic [TRN_W-1:0] TRN_RST   = 12'h000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 13'h0000;
   // value is arbitrary
   localparam logic [DATA_W-1:0] UNLOCK_CODE_DFLT = 13'h0a5c;

   //=============================================================
   // turns counter octants and limits
   localparam logic [OCT_W-1:0] OCT_ZERO = 3'h0;
   localparam logic [OCT_W-1:0] OCT_HALF = 3'h4;
   localparam logic [OCT_W-1:0] OCT_ONE  = 3'h1;
   localparam logic [TRN_W-1:0] TRN_ONE  = 12'h001;
   localparam logic [TRN_W-1:0] TRN_MAX  = 12'h7ff;
   localparam logic [TRN_W-1:0] TRN_MIN  = 12'h800;
endpackage

// >>> hdl/asrb_top.sv
// angle sensor host register bank: angle, turns, faults, control, unlock
`timescale 1ns/10ps
module asrb_top
   import asrb_pkg::*;
#(
   parameter logic [DATA_W-1:0] UNLOCK_CODE = UNLOCK_CODE_DFLT
)(
   // clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              srst_i,
   // register port
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              wr_i,
   input  wire logic [DATA_W-1:0] wr_data_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rd_data_o,
   output logic                   rd_valid_o,
   // angle measurement
   input  wire logic              sample_valid_i,
   input  wire logic [ANG_W-1:0]  raw_angle_i,
   input  wire logic              rotation_direction_sel_i,
   input  wire logic              turn_step_select_i,
   // fault events
   input  wire logic              supply_loss_i,
   input  wire logic              magnet_loss_i,
   input  wire logic              internal_logic_fault_i,
   input  wire logic              overheat_i,
   input  wire logic              nvm_corrected_i,
   input  wire logic              nvm_uncorrectable_i,
   input  wire logic              sensor_path_selftest_fault_i,
   input  wire logic              logic_selftest_fault_i,
   input  wire logic              link_coding_fault_i,
   // fault masks, one per flag bit
   input  wire logic [FLT_W-1:0]  fault_mask_first_i,
   input  wire logic [FLT_W-1:0]  fault_mask_second_i,
   // status and commands
   output logic                   err_summary_o,
   output logic                   ext_access_o,
   output logic                   selftest_launch_o,
   output logic                   rpm_mode_o,
   output logic                   sleep_kind_select_o
);
   logic [ANG_W-1:0]  current_angle;
   logic [ANG_W-1:0]  next_angle;
   logic [TRN_W-1:0]  turns_total;
   logic              turns_ovf;
   logic [FLT_W-1:0]  fault_flags_first;
   logic [FLT_W-1:0]  next_flt1;
   logic [FLT_W-1:0]  fault_flags_secondary;
   logic [FLT_W-1:0]  next_flt2;
   logic [FLT_W-1:0]  ev1;
   logic [FLT_W-1:0]  ev2;
   logic              next_summary;
   logic              next_rpm;
   logic              next_sleep;
   logic              next_launch;
   logic              next_access;
   logic [DATA_W-1:0] next_rd_data;
   logic              wr_ctrl;
   logic              wr_unlock;
   logic              fault_clear;
   logic              turns_clear;

   // address match, shared by write decode and read mux
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   //=============================================================
   // write decode
   // writes to read-only or unmapped offsets are dropped silently
   always_comb begin
      wr_ctrl     = wr_i && addr_hit(addr_i, OFS_CTRL);
      wr_unlock   = wr_i && addr_hit(addr_i, OFS_UNLOCK);
      fault_clear = wr_ctrl && wr_data_i[CB_FLT_CLR];
      turns_clear = wr_ctrl && wr_data_i[CB_TRN_CLR];
   end

   //=============================================================
   // angle path
   // direction applied here so counter and register see the same value
   always_comb begin
      next_angle = current_angle;
      if (sample_valid_i) begin
         if (rotation_direction_sel_i) begin
            next_angle = ANG_RST - raw_angle_i;
         end else begin
            next_angle = raw_angle_i;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         current_angle <= ANG_RST;
      end else begin
         current_angle <= next_angle;
      end
   end

   // counter updates on the same edge as the angle register
   asrb_turns u_turns (
      .core_clk_i     (core_clk_i),
      .srst_i         (srst_i),
      .sample_valid_i (sample_valid_i),
      .angle_i        (next_angle),
      .step45_i       (turn_step_select_i),
      .clear_i        (turns_clear),
      .turns_o        (turns_total),
      .ovf_o          (turns_ovf)
   );

   //=============================================================
   // fault flags
   // a new event in the clear cycle wins, so nothing is lost
   always_comb begin
      ev1              = '0;
      ev1[FP_SUPPLY]   = supply_loss_i;
      ev1[FP_MAGNET]   = magnet_loss_i;
      ev1[FP_INTERNAL] = internal_logic_fault_i;
      ev1[FP_REV_OVF]  = turns_ovf;
      ev1[FP_OVERHEAT] = overheat_i;
      ev1[FP_NVM_FIX]  = nvm_corrected_i;
      ev1[FP_NVM_BAD]  = nvm_uncorrectable_i;
      ev2              = '0;
      ev2[FS_SENSOR]   = sensor_path_selftest_fault_i;
      ev2[FS_LOGIC]    = logic_selftest_fault_i;
      ev2[FS_LINK]     = link_coding_fault_i;
      next_flt1        = ev1 | (fault_flags_first & ~{FLT_W{fault_clear}});
      next_flt2        = (ev2 | (fault_flags_secondary & ~{FLT_W{fault_clear}})) & FLT2_IMPL;
      // masks gate only the summary, never the flag itself
      next_summary     = |(next_flt1 & ~fault_mask_first_i) | |(next_flt2 & ~fault_mask_second_i);
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         fault_flags_first     <= FLT1_RST;
         fault_flags_secondary <= FLT2_RST;
         err_summary_o         <= 1'b1;
      end else begin
         fault_flags_first     <= next_flt1;
         fault_flags_secondary <= next_flt2;
         err_summary_o         <= next_summary;
      end
   end

   //=============================================================
   // control register and unlock word
   // any other word written to the unlock offset withdraws access
   always_comb begin
      next_rpm    = rpm_mode_o;
      next_sleep  = sleep_kind_select_o;
      next_launch = wr_ctrl && wr_data_i[CB_SELFTEST];
      next_access = ext_access_o;
      if (wr_ctrl) begin
         next_rpm   = wr_data_i[CB_RPM];
         next_sleep = wr_data_i[CB_SLEEP];
      end
      if (wr_unlock) begin
         next_access = (wr_data_i == UNLOCK_CODE);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rpm_mode_o          <= 1'b0;
         sleep_kind_select_o <= 1'b0;
         selftest_launch_o   <= 1'b0;
         ext_access_o        <= 1'b0;
      end else begin
         rpm_mode_o          <= next_rpm;
         sleep_kind_select_o <= next_sleep;
         selftest_launch_o   <= next_launch;
         ext_access_o        <= next_access;
      end
   end

   //=============================================================
   // read mux
   // whole registers are captured in one cycle, so halves never mix
   always_comb begin
      next_rd_data = DATA_ZERO;
      if (addr_hit(addr_i, OFS_ANGLE)) begin
         next_rd_data = {current_angle, 1'b0};
      end else if (addr_hit(addr_i, OFS_TURNS)) begin
         next_rd_data = {1'b0, turns_total};
      end else if (addr_hit(addr_i, OFS_FLT1)) begin
         next_rd_data = {{(DATA_W-FLT_W){1'b0}}, fault_flags_first};
      end else if (addr_hit(addr_i, OFS_FLT2)) begin
         next_rd_data = {{(DATA_W-FLT_W){1'b0}}, fault_flags_secondary};
      end else if (addr_hit(addr_i, OFS_CTRL)) begin
         // command bits read zero, upper bits read zero
         next_rd_data = {{(DATA_W-CTL_W){1'b0}}, 2'b00, rpm_mode_o, sleep_kind_select_o, 1'b0};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rd_data_o  <= DATA_ZERO;
         rd_valid_o <= 1'b0;
      end else begin
         rd_data_o  <= rd_i ? next_rd_data : rd_data_o;
         rd_valid_o <= rd_i;
      end
   end

   //=============================================================
   // assertions
   property p_angle_read;
      @(posedge core_clk_i) disable iff (srst_i)
      (rd_i && addr_i == OFS_ANGLE) |=> rd_data_o == {$past(current_angle), 1'b0};
   endproperty
   a_angle_read: assert property (p_angle_read) else $error("angle read wrong");

   property p_angle_dir;
      @(posedge core_clk_i) disable iff (srst_i)
      (sample_valid_i && rotation_direction_sel_i) |=> current_angle == ANG_RST - $past(raw_angle_i);
   endproperty
   a_angle_dir: assert property (p_angle_dir) else $error("reversed angle wrong");

   property p_flt_hold;
      @(posedge core_clk_i) disable iff (srst_i)
      !$past(fault_clear) |-> (($past(fault_flags_first) & ~fault_flags_first) == '0);
   endproperty
   a_flt_hold: assert property (p_flt_hold) else $error("fault flag dropped");

   // summary is forced high in reset whatever the masks, so skip the edge just after it
   property p_summary;
      @(posedge core_clk_i) disable iff (srst_i)
      !$past(srst_i) |-> err_summary_o == (|(fault_flags_first & ~$past(fault_mask_first_i))
                      | |(fault_flags_secondary & ~$past(fault_mask_second_i)));
   endproperty
   a_summary: assert property (p_summary) else $error("summary mismatch");

   property p_masked_set;
      @(posedge core_clk_i) disable iff (srst_i)
      (magnet_loss_i && fault_mask_first_i[FP_MAGNET]) |=> fault_flags_first[FP_MAGNET];
   endproperty
   a_masked_set: assert property (p_masked_set) else $error("masked flag not set");

   property p_nvm_bad;
      @(posedge core_clk_i) disable iff (srst_i)
      nvm_uncorrectable_i |=> fault_flags_first[FP_NVM_BAD] ##1 (fault_flags_first[FP_NVM_BAD] || $past(fault_clear));
   endproperty
   a_nvm_bad: assert property (p_nvm_bad) else $error("nvm flag missing");

   property p_clear;
      @(posedge core_clk_i) disable iff (srst_i)
      (fault_clear && ev1 == '0) |=> fault_flags_first == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("fault clear failed");

   property p_ctrl_read;
      @(posedge core_clk_i) disable iff (srst_i)
      (rd_i && addr_i == OFS_CTRL) |=> rd_data_o[CB_SELFTEST] == 1'b0 && rd_data_o[CB_TRN_CLR] == 1'b0
                                      && rd_data_o[CB_FLT_CLR] == 1'b0;
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("command bit read one");

   property p_unlock;
      @(posedge core_clk_i) disable iff (srst_i)
      $rose(ext_access_o) |-> $past(wr_unlock && wr_data_i == UNLOCK_CODE);
   endproperty
   a_unlock: assert property (p_unlock) else $error("access without unlock");

   property p_same_edge;
      @(posedge core_clk_i) disable iff (srst_i)
      $changed(turns_total) && !$past(turns_clear) |-> $past(sample_valid_i);
   endproperty
   a_same_edge: assert property (p_same_edge) else $error("turns moved without sample");

   property p_turns_read;
      @(posedge core_clk_i) disable iff (srst_i)
      (rd_i && addr_i == OFS_TURNS) |=> rd_valid_o && rd_data_o == {1'b0, $past(turns_total)};
   endproperty
   a_turns_read: assert property (p_turns_read) else $error("turns read wrong");

   property p_flt2_upper;
      @(posedge core_clk_i) disable iff (srst_i)
      (rd_i && addr_i == OFS_FLT2) |=> rd_data_o[DATA_W-1:FLT_W] == '0;
   endproperty
   a_flt2_upper: assert property (p_flt2_upper) else $error("unused bits read one");

   property p_flt1_ro;
      @(posedge core_clk_i) disable iff (srst_i)
      (wr_i && addr_i == OFS_FLT1 && ev1 == '0) |=> $stable(fault_flags_first);
   endproperty
   a_flt1_ro: assert property (p_flt1_ro) else $error("fault register took a write");

   property p_ctrl_write;
      @(posedge core_clk_i) disable iff (srst_i)
      wr_ctrl |=> rpm_mode_o == $past(wr_data_i[CB_RPM]) && sleep_kind_select_o == $past(wr_data_i[CB_SLEEP]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   // launch is a pulse exactly one edge after the command write
   property p_launch;
      @(posedge core_clk_i) disable iff (srst_i)
      !$past(srst_i) |-> selftest_launch_o == $past(wr_ctrl && wr_data_i[CB_SELFTEST]);
   endproperty
   a_launch: assert property (p_launch) else $error("launch pulse wrong");

   c_launch: cover property (@(posedge core_clk_i) disable iff (srst_i) selftest_launch_o);
   c_unlock: cover property (@(posedge core_clk_i) disable iff (srst_i) $rose(ext_access_o));
   c_clear:  cover property (@(posedge core_clk_i) disable iff (srst_i) fault_clear ##1 !err_summary_o);
   c_turn:   cover property (@(posedge core_clk_i) disable iff (srst_i) $changed(turns_total));
endmodule // asrb_top

// >>> hdl/asrb_turns.sv
// turns counter: counts threshold crossings of the directed angle
`timescale 1ns/10ps
module asrb_turns
   import asrb_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             srst_i,
   // directed angle samples
   input  wire logic             sample_valid_i,
   input  wire logic [ANG_W-1:0] angle_i,
   input  wire logic             step45_i,
   input  wire logic             clear_i,
   // count
   output logic      [TRN_W-1:0] turns_o,
   output logic                  ovf_o
);
   logic [OCT_W-1:0] prev_oct;
   logic [OCT_W-1:0] next_prev_oct;
   logic             primed;
   logic             next_primed;
   logic [TRN_W-1:0] next_turns;
   logic             next_ovf;
   logic [OCT_W-1:0] oct;
   logic             cnt_f;
   logic             cnt_b;

   // a boundary at the start of octant b counts in this threshold mode
   function automatic logic counted(input logic [OCT_W-1:0] b, input logic s45);
      return s45 || (b == OCT_ZERO) || (b == OCT_HALF);
   endfunction

   // samples must move no more than 45 degrees apart, else crossings are missed
   always_comb begin
      oct           = angle_i[ANG_W-1 -: OCT_W];
      cnt_f         = primed && (oct == prev_oct + OCT_ONE) && counted(oct, step45_i);
      cnt_b         = primed && (oct == prev_oct - OCT_ONE) && counted(prev_oct, step45_i);
      next_turns    = turns_o;
      next_ovf      = 1'b0;
      next_prev_oct = prev_oct;
      next_primed   = primed;
      if (clear_i) begin
         next_turns = TRN_RST;
      end else if (sample_valid_i && cnt_f) begin
         next_turns = turns_o + TRN_ONE;
         next_ovf   = (turns_o == TRN_MAX);
      end else if (sample_valid_i && cnt_b) begin
         next_turns = turns_o - TRN_ONE;
         next_ovf   = (turns_o == TRN_MIN);
      end
      if (sample_valid_i) begin
         next_prev_oct = oct;
         next_primed   = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         turns_o  <= TRN_RST;
         ovf_o    <= 1'b0;
         prev_oct <= OCT_ZERO;
         primed   <= 1'b0;
      end else begin
         turns_o  <= next_turns;
         ovf_o    <= next_ovf;
         prev_oct <= next_prev_oct;
         primed   <= next_primed;
      end
   end

   //=============================================================
   // assertions
   property p_step45_fwd;
      @(posedge core_clk_i) disable iff (srst_i)
      (sample_valid_i && !clear_i && step45_i && primed && oct == prev_oct + OCT_ONE)
         |=> turns_o == $past(turns_o) + TRN_ONE;
   endproperty
   a_step45_fwd: assert property (p_step45_fwd) else $error("missed 45 degree step");

   property p_half_skip;
      @(posedge core_clk_i) disable iff (srst_i)
      (sample_valid_i && !clear_i && !step45_i && primed && oct == prev_oct + OCT_ONE
       && oct != OCT_ZERO && oct != OCT_HALF) |=> turns_o == $past(turns_o);
   endproperty
   a_half_skip: assert property (p_half_skip) else $error("counted non half boundary");

   property p_back_wrap;
      @(posedge core_clk_i) disable iff (srst_i)
      (sample_valid_i && !clear_i && primed && oct == prev_oct - OCT_ONE && prev_oct == OCT_ZERO
       && turns_o == TRN_RST) |=> turns_o == TRN_RST - TRN_ONE;
   endproperty
   a_back_wrap: assert property (p_back_wrap) else $error("minus one not all ones");
endmodule // asrb_turns

// >>> sim/asrb_host.sv
// host model: issues register reads and writes and notes the expected read data
`timescale 1ns/10ps
module asrb_host
   import asrb_pkg::*;
(
   // clock
   input  wire logic              core_clk_i,
   // register port
   output logic      [ADDR_W-1:0] addr_o,
   output logic                   wr_o,
   output logic      [DATA_W-1:0] wr_data_o,
   output logic                   rd_o
);
   logic [DATA_W-1:0] exp_q[$];
   logic [ADDR_W-1:0] adr_q[$];

   //=============================================================
   // idle bus
   initial begin
      addr_o    = 8'h00;
      wr_o      = 1'b0;
      wr_data_o = 13'h0000;
      rd_o      = 1'b0;
   end

   // one-cycle write; unlock word and fault clear go only through here
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge core_clk_i);
      addr_o    = a;
      wr_data_o = d;
      wr_o      = 1'b1;
      @(negedge core_clk_i);
      wr_o      = 1'b0;
      addr_o    = ~a; // released lines show no stale copy
      wr_data_o = ~d;
   endtask

   // one-cycle read, expectation queued for the watcher
   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(negedge core_clk_i);
      addr_o = a;
      rd_o   = 1'b1;
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(negedge core_clk_i);
      rd_o   = 1'b0;
      addr_o = ~a;
   endtask
endmodule // asrb_host

// >>> sim/testbench.sv
// self-checking bench for the angle sensor host register bank
`timescale 1ns/10ps
module testbench;
   import asrb_pkg::*;
   localparam logic [DATA_W-1:0] UNLOCK_VAL = 13'h0c3d; // value is arbitrary
   logic              core_clk_i;
   logic              srst_i;
   logic [ADDR_W-1:0] addr;
   logic              wr;
   logic [DATA_W-1:0] wd;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   logic              rvalid;
   logic              sv;
   logic [ANG_W-1:0]  raw;
   logic              dsel;
   logic              step;
   logic [13:0]       ev;
   logic [13:0]       msk;
   logic              summ;
   logic              ext;
   logic              launch;
   logic              rpm;
   logic              sleep;
   // bench model of the measurement and flag state
   logic [TRN_W-1:0]  cnt;
   logic [ANG_W-1:0]  dang;
   logic [ANG_W-1:0]  ra;
   logic [OCT_W-1:0]  poct;
   logic [FLT_W-1:0]  f1;
   logic [FLT_W-1:0]  f2;
   bit                primed;
   int                seed = 95719;
   int                dlt;
   int                failures = 0;
   int                n_checks = 0;
   int                cyc = 0;

   asrb_host u_asrb_host (.core_clk_i(core_clk_i), .addr_o(addr), .wr_o(wr), .wr_data_o(wd), .rd_o(rd));

   asrb_top #(.UNLOCK_CODE(UNLOCK_VAL)) u_asrb_top (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr), .wr_i(wr), .wr_data_i(wd), .rd_i(rd),
      .rd_data_o(rdata), .rd_valid_o(rvalid), .sample_valid_i(sv), .raw_angle_i(raw),
      .rotation_direction_sel_i(dsel), .turn_step_select_i(step), .supply_loss_i(ev[0]),
      .magnet_loss_i(ev[1]), .internal_logic_fault_i(ev[2]), .overheat_i(ev[4]), .nvm_corrected_i(ev[5]),
      .nvm_uncorrectable_i(ev[6]), .sensor_path_selftest_fault_i(ev[10]), .logic_selftest_fault_i(ev[11]),
      .link_coding_fault_i(ev[13]), .fault_mask_first_i(msk[6:0]), .fault_mask_second_i(msk[13:7]),
      .err_summary_o(summ), .ext_access_o(ext), .selftest_launch_o(launch), .rpm_mode_o(rpm),
      .sleep_kind_select_o(sleep));

   //=============================================================
   // reporting
   task automatic check(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   //=============================================================
   // one angle sample; the model mirrors the octant crossing count
   task automatic samp(input logic [ANG_W-1:0] a);
      logic [OCT_W-1:0] o;
      @(negedge core_clk_i);
      sv  = 1'b1;
      raw = a;
      dang = dsel ? 12'h000 - a : a;
      o = dang[11:9];
      if (primed && o == poct + OCT_ONE && (step || o == OCT_ZERO || o == OCT_HALF)) begin
         if (cnt == TRN_MAX) f1[FP_REV_OVF] = 1'b1;
         cnt = cnt + TRN_ONE;
      end
      if (primed && o == poct - OCT_ONE && (step || poct == OCT_ZERO || poct == OCT_HALF)) begin
         if (cnt == TRN_MIN) f1[FP_REV_OVF] = 1'b1;
         cnt = cnt - TRN_ONE;
      end
      poct = o;
      primed = 1'b1;
   endtask

   // stop sampling, then read angle and turns back
   task automatic meas;
      @(negedge core_clk_i);
      sv = 1'b0;
      u_asrb_host.rd_reg(OFS_ANGLE, {dang, 1'b0});
      u_asrb_host.rd_reg(OFS_TURNS, {1'b0, cnt});
   endtask

   //=============================================================
   // read watcher: oldest expectation against each returned value
   always @(negedge core_clk_i) begin
      if (rvalid === 1'b1) begin
         if (u_asrb_host.exp_q.size() == 0) begin
            check("unrequested read", rdata, 13'h1fff);
         end else begin
            check($sformatf("read at %h", u_asrb_host.adr_q.pop_front()), rdata, u_asrb_host.exp_q.pop_front());
         end
      end
   end

   // clock and hang guard
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc > 20000) begin
         failures++;
         close_out;
      end
   end

   //=============================================================
   // main sequence
   initial begin
      srst_i = 1'b1; sv = 1'b0; raw = 12'h000; dsel = 1'b0; step = 1'b0; ev = 14'h0; msk = 14'h0;
      cnt = 12'h000; dang = 12'h000; ra = 12'h000; poct = 3'h0; primed = 1'b0;
      f1 = FLT1_RST; f2 = FLT2_RST;
      // count rising edges: the clock's first step out of unknown can look like a falling one
      repeat (3) @(posedge core_clk_i);
      @(negedge core_clk_i);
      srst_i = 1'b0;
      check("summary", {12'h0, summ}, 13'h0001);
      u_asrb_host.rd_reg(OFS_FLT1, 13'h0001);
      u_asrb_host.rd_reg(OFS_FLT2, 13'h0001);
      u_asrb_host.rd_reg(OFS_CTRL, 13'h0000);
      u_asrb_host.rd_reg(8'h33, 13'h0000);
      meas;
      $display("test reset done");
      // random walk of the angle with direction and step changes
      for (int i = 0; i < 300; i++) begin
         dlt = $random(seed) % 1280;
         ra = ra + dlt[11:0];
         dsel = i[4];
         step = (i >= 150);
         samp(ra);
         meas;
      end
      $display("test walk done");
      // minus one, then wrap past the positive limit in 45 degree steps
      dsel = 1'b0;
      samp(12'h100);
      u_asrb_host.wr_reg(OFS_CTRL, 13'h0009);
      cnt = 12'h000; f1 = 7'h00; f2 = 7'h00;
      samp(12'hf00);
      meas;
      samp(12'h100);
      for (int i = 1; i <= 2048; i++) samp(12'h100 + 12'(i * 'h200));
      meas;
      u_asrb_host.rd_reg(OFS_FLT1, {6'h0, f1});
      $display("test overflow done");
      // writes to read-only places change nothing
      u_asrb_host.wr_reg(OFS_ANGLE, 13'h1fff);
      u_asrb_host.wr_reg(OFS_TURNS, 13'h1fff);
      u_asrb_host.wr_reg(OFS_FLT1, 13'h1fff);
      u_asrb_host.wr_reg(OFS_FLT2, 13'h1fff);
      u_asrb_host.wr_reg(8'h33, 13'h1fff);
      meas;
      u_asrb_host.rd_reg(OFS_FLT1, {6'h0, f1});
      u_asrb_host.rd_reg(OFS_FLT2, {6'h0, f2});
      // each fault event against a random mask, then cleared
      u_asrb_host.wr_reg(OFS_CTRL, 13'h0001);
      for (int k = 0; k < 14; k++) begin
         if (k != 3 && ((14'h2c77 >> k) & 14'h1) == 14'h1) begin
            msk = 14'($random(seed));
            @(negedge core_clk_i);
            ev[k] = 1'b1;
            @(negedge core_clk_i);
            ev[k] = 1'b0;
            check("summary", {12'h0, summ}, {12'h0, ~msk[k]});
            u_asrb_host.rd_reg(k < 7 ? OFS_FLT1 : OFS_FLT2, 13'h0001 << (k % 7));
            u_asrb_host.wr_reg(OFS_CTRL, 13'h0001);
            check("summary", {12'h0, summ}, 13'h0000);
            u_asrb_host.rd_reg(k < 7 ? OFS_FLT1 : OFS_FLT2, 13'h0000);
         end
      end
      $display("test faults done");
      // control fields and self-clearing launch
      u_asrb_host.wr_reg(OFS_CTRL, 13'h1ff6);
      check("launch", {12'h0, launch}, 13'h0001);
      @(negedge core_clk_i);
      check("launch", {12'h0, launch}, 13'h0000);
      check("modes", {11'h0, rpm, sleep}, 13'h0003);
      u_asrb_host.rd_reg(OFS_CTRL, 13'h0006);
      u_asrb_host.wr_reg(OFS_CTRL, 13'h0000);
      u_asrb_host.rd_reg(OFS_CTRL, 13'h0000);
      // unlock word: wrong, right, wrong again
      u_asrb_host.wr_reg(OFS_UNLOCK, UNLOCK_VAL ^ 13'h0001);
      check("access", {12'h0, ext}, 13'h0000);
      u_asrb_host.wr_reg(OFS_UNLOCK, UNLOCK_VAL);
      check("access", {12'h0, ext}, 13'h0001);
      u_asrb_host.rd_reg(OFS_UNLOCK, 13'h0000);
      u_asrb_host.wr_reg(OFS_UNLOCK, 13'h0000);
      check("access", {12'h0, ext}, 13'h0000);
      repeat (3) @(negedge core_clk_i);
      check("pending reads", 13'(u_asrb_host.exp_q.size()), 13'h0000);
      $display("test control done");
      close_out;
   end
endmodule // testbench
